/* pkg/rcsr_pkg.sv */
// package for the reset cause and slow rc oscillator control/status block
// assumes a single ahb-lite slave on a 200 MHz hclk
package rcsr_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CSR = 8'h24;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;
  localparam logic [31:0] CSR_RESET = 32'h0C00_0000;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int BIT_LPWR = 31;
  localparam int BIT_WWDG = 30;
  localparam int BIT_IWDG = 29;
  localparam int BIT_SOFT = 28;
  localparam int BIT_POR = 27;
  localparam int BIT_PIN = 26;
  localparam int BIT_REMOVE = 24;
  localparam int BIT_RDY = 1;
  localparam int BIT_EN = 0;
  localparam int FLAG_LSB = 26;
  localparam int NUM_FLAGS = 6;

  // interrupt status bits: ready rose, ready fell
  localparam int IRQ_RDY_RISE = 0;
  localparam int IRQ_RDY_FALL = 1;
  localparam int NUM_IRQ = 2;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int WAIT_STATES = 3;
  localparam int RC_OFF_CYCLES = 3;
  localparam int RC_START_CYCLES = 4;

  // reset causes, one bit per source in register order 31..26
  typedef struct packed {
    logic low_power;
    logic window_wd;
    logic indep_wd;
    logic software;
    logic power_on_down;
    logic ext_pin;
  } rcsr_cause_type;

  typedef enum logic [1:0] {
    RCSR_IDLE = 2'b00,
    RCSR_WAIT = 2'b01,
    RCSR_DATA = 2'b11
  } rcsr_bus_state_type;

endpackage

/* hdl/rcsr_top.sv */
// reset cause flags and slow rc oscillator control/status register
// assumes hclk 200 MHz, power reset and system reset both async low,
// and a slow rc clock arriving as a plain pin input sampled here
`timescale 1ns/1ps
`default_nettype none

// Operation
// - register at 0x24, reset 0x0C000000; system reset spares cause flags
// - byte, half and word accesses; up to 3 wait states back to back
// - low-power reset sets bit 31
// - window watchdog reset sets bit 30
// - independent watchdog reset sets bit 29
// - software reset sets bit 28
// - power-on/down reset sets bit 27
// - external pin reset sets bit 26
// - writing 1 to bit 24 clears all six flags; 0 does nothing
// - bit 25 and bits 23:2 read zero
// - bit 0 switches the slow rc oscillator on and off
// - bit 1 shows oscillator ready, hardware driven, read only
// - ready drops after 3 slow clock cycles once enable clears
module rcsr_top #(
  parameter int START_CYCLES = rcsr_pkg::RC_START_CYCLES
) (
  // clock and resets
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic power_resetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // reset cause pulses, one hclk wide, from the reset controller
  input wire rcsr_pkg::rcsr_cause_type cause_event,
  // slow rc oscillator
  input wire logic slow_rc_clk_pin,
  output logic slow_rc_enable,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------------
  // bus front end
  // ----------------------------------------------------------------------
  rcsr_pkg::rcsr_bus_state_type state;
  logic [7:0] addr;
  logic wr;
  logic [2:0] size;
  logic [1:0] wait_cnt;
  logic recent;
  logic take;
  logic commit;
  logic successive;
  logic [7:0] word_addr;
  logic [7:0] rd_addr;
  logic csr_wr;
  logic status_wr;
  logic mask_wr;
  logic [31:0] lane_mask;
  logic [31:0] wmask;
  logic [31:0] rd_val;

  rcsr_pkg::rcsr_cause_type flags;
  logic slow_rc_ready;
  logic [rcsr_pkg::NUM_IRQ-1:0] irq_status;
  logic [rcsr_pkg::NUM_IRQ-1:0] irq_mask;

  assign take = hsel && hready && htrans[1] && (state != rcsr_pkg::RCSR_WAIT);
  assign commit = (state == rcsr_pkg::RCSR_DATA);
  assign hreadyout = (state != rcsr_pkg::RCSR_WAIT);
  assign hresp = 1'b0;
  // overlapping a data phase, or directly following one, both count as successive
  assign successive = commit || recent;
  // registers are whole words; byte and half accesses decode to their word
  assign word_addr = {addr[7:2], 2'b00};
  // reads decode the address phase itself, so a zero-wait data phase has its data
  assign rd_addr = take ? {haddr[7:2], 2'b00} : word_addr;

  // address phase fields, held through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr <= 8'h00;
      wr <= 1'b0;
      size <= 3'h0;
    end else if (take) begin
      addr <= haddr[7:0];
      wr <= hwrite;
      size <= hsize;
    end
  end

  // successive accesses pay the full wait budget, isolated ones none
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= rcsr_pkg::RCSR_IDLE;
    end else begin
      case (state)
        rcsr_pkg::RCSR_IDLE, rcsr_pkg::RCSR_DATA: begin
          if (take && successive) begin
            state <= rcsr_pkg::RCSR_WAIT;
          end else if (take) begin
            state <= rcsr_pkg::RCSR_DATA;
          end else begin
            state <= rcsr_pkg::RCSR_IDLE;
          end
        end
        rcsr_pkg::RCSR_WAIT: begin
          if (wait_cnt == 2'h0) begin
            state <= rcsr_pkg::RCSR_DATA;
          end
        end
        default: state <= rcsr_pkg::RCSR_IDLE;
      endcase
    end
  end

  // wait states left; loaded when a successive access is taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_cnt <= 2'h0;
    end else if (take && successive) begin
      wait_cnt <= 2'(rcsr_pkg::WAIT_STATES - 1);
    end else if (state == rcsr_pkg::RCSR_WAIT && wait_cnt != 2'h0) begin
      wait_cnt <= wait_cnt - 2'h1;
    end
  end

  // an access counts as successive if one completed in the previous cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      recent <= 1'b0;
    end else begin
      recent <= commit;
    end
  end

  // byte lanes from size and low address bits
  always_comb begin
    lane_mask = 32'h0000_0000;
    case (size)
      3'h0: lane_mask = 32'h0000_00FF << {addr[1:0], 3'h0};
      3'h1: lane_mask = addr[1] ? 32'hFFFF_0000 : 32'h0000_FFFF;
      default: lane_mask = 32'hFFFF_FFFF;
    endcase
    wmask = (commit && wr) ? (lane_mask & hwdata) : 32'h0000_0000;
  end

  // one strobe per register, true in the cycle that ends a write data phase
  assign csr_wr = commit && wr && (word_addr == rcsr_pkg::OFS_CSR);
  assign status_wr = commit && wr && (word_addr == rcsr_pkg::OFS_IRQ_STATUS);
  assign mask_wr = commit && wr && (word_addr == rcsr_pkg::OFS_IRQ_MASK);

  // ----------------------------------------------------------------------
  // reset cause flags
  // ----------------------------------------------------------------------
  logic do_remove;
  assign do_remove = csr_wr && wmask[rcsr_pkg::BIT_REMOVE];

  // only the power reset resets these, to the power-on/down and pin flags, so a system reset keeps them
  always_ff @(posedge hclk or negedge power_resetn) begin
    if (!power_resetn) begin
      flags <= rcsr_pkg::rcsr_cause_type'(rcsr_pkg::CSR_RESET[31:rcsr_pkg::FLAG_LSB]);
    end else begin
      // a new cause in the clearing cycle still sets its flag
      flags <= (do_remove ? '0 : flags) | cause_event;
    end
  end

  // ----------------------------------------------------------------------
  // slow rc oscillator enable and ready
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_rc_enable <= rcsr_pkg::CSR_RESET[rcsr_pkg::BIT_EN];
    end else if (csr_wr && lane_mask[rcsr_pkg::BIT_EN]) begin
      slow_rc_enable <= hwdata[rcsr_pkg::BIT_EN];
    end
  end

  // three-stage sampler; edges counted when stages two and three agree
  logic [2:0] rc_sync;
  logic rc_level;
  logic rc_edge;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rc_sync <= 3'h0;
    end else begin
      rc_sync <= {rc_sync[1:0], slow_rc_clk_pin};
    end
  end

  // settled level starts at the pin's idle low, so leaving reset makes no false edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rc_level <= 1'b0;
    end else if (rc_sync[2] == rc_sync[1]) begin
      rc_level <= rc_sync[2];
    end
  end
  assign rc_edge = (rc_sync[2] == rc_sync[1]) && rc_sync[2] && !rc_level;

  // ready rises after a few stable slow edges, falls 3 slow edges after off
  logic [2:0] rc_cnt;
  logic rc_settling;
  logic rc_start_done;
  logic rc_stop_done;
  // the counter runs only while enable and ready disagree; a stopped slow clock stalls it
  assign rc_settling = (slow_rc_enable != slow_rc_ready);
  assign rc_start_done = rc_settling && rc_edge && slow_rc_enable && (rc_cnt == 3'(START_CYCLES - 1));
  assign rc_stop_done = rc_settling && rc_edge && !slow_rc_enable && (rc_cnt == 3'(rcsr_pkg::RC_OFF_CYCLES - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rc_cnt <= 3'h0;
    end else if (!rc_settling || rc_start_done || rc_stop_done) begin
      rc_cnt <= 3'h0;
    end else if (rc_edge) begin
      rc_cnt <= rc_cnt + 3'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_rc_ready <= rcsr_pkg::CSR_RESET[rcsr_pkg::BIT_RDY];
    end else if (rc_start_done) begin
      slow_rc_ready <= 1'b1;
    end else if (rc_stop_done) begin
      slow_rc_ready <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // interrupts on ready transitions
  // ----------------------------------------------------------------------
  logic rdy_q;
  logic [rcsr_pkg::NUM_IRQ-1:0] irq_set;
  logic [rcsr_pkg::NUM_IRQ-1:0] irq_clr;
  assign irq_set = {rdy_q & ~slow_rc_ready, slow_rc_ready & ~rdy_q};
  assign irq_clr = status_wr ? wmask[rcsr_pkg::NUM_IRQ-1:0] : '0;

  // ready is low after reset, so the delayed copy starts low too
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdy_q <= 1'b0;
    end else begin
      rdy_q <= slow_rc_ready;
    end
  end

  // a new event in the clearing cycle wins over the write of one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= '0;
    end else if (mask_wr && lane_mask[0]) begin
      irq_mask <= hwdata[rcsr_pkg::NUM_IRQ-1:0];
    end
  end
  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000; // reserved bits and unmapped offsets read zero
    case (rd_addr)
      rcsr_pkg::OFS_CSR: begin
        rd_val[31:rcsr_pkg::FLAG_LSB] = flags;
        rd_val[rcsr_pkg::BIT_RDY] = slow_rc_ready;
        rd_val[rcsr_pkg::BIT_EN] = slow_rc_enable;
      end
      rcsr_pkg::OFS_IRQ_STATUS: rd_val[rcsr_pkg::NUM_IRQ-1:0] = irq_status;
      rcsr_pkg::OFS_IRQ_MASK: rd_val[rcsr_pkg::NUM_IRQ-1:0] = irq_mask;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // registered read data, loaded in the cycle before the data phase ends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= rd_val;
    end
  end

endmodule // rcsr_top

`default_nettype wire

/* tb/rcsr_top_checker.sv */
// assertions on the ports of rcsr_top, bound after the module
// assumes one hclk domain and system reset hresetn
`timescale 1ns/1ps
`default_nettype none
module rcsr_checker (
  // watched ports
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire rcsr_pkg::rcsr_cause_type cause_event,
  input wire logic slow_rc_enable
);
  // ----------------------------------------
  // data phase tracking
  // ----------------------------------------
  logic acc, dp, wr, csr, un, rd_end, done_q;
  assign acc = hsel && hready && htrans[1] && hreadyout;
  assign rd_end = dp && !wr && hreadyout;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp <= 1'b0;
      wr <= 1'b0;
      csr <= 1'b0;
      un <= 1'b0;
    end else if (acc) begin
      dp <= 1'b1;
      wr <= hwrite;
      csr <= haddr[7:2] == 6'h09;
      un <= !(haddr[7:2] inside {6'h09, 6'h0A, 6'h0B});
    end else if (hreadyout) begin
      dp <= 1'b0;
    end
  end
  // a data phase that ended on the previous edge makes the next access successive
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= dp && hreadyout;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_resp; hresp == 1'b0; endproperty
  a_resp: assert property (p_resp) else $error("error response");
  property p_iso; acc && !dp && !done_q |=> hreadyout; endproperty
  a_iso: assert property (p_iso) else $error("isolated access waited");
  property p_b2b; acc && (dp || done_q) |=> !hreadyout [*3] ##1 hreadyout; endproperty
  a_b2b: assert property (p_b2b) else $error("back to back wait count");
  property p_en; $changed(slow_rc_enable) |-> $past(dp && wr && csr && hreadyout); endproperty
  a_en: assert property (p_en) else $error("enable moved without write");
  property p_res; rd_end && csr |-> hrdata[25] == 1'b0 && hrdata[23:2] == 22'h0; endproperty
  a_res: assert property (p_res) else $error("reserved bits set");
  property p_enrd; rd_end && csr |-> hrdata[0] == slow_rc_enable; endproperty
  a_enrd: assert property (p_enrd) else $error("enable readback");
  property p_un; rd_end && un |-> hrdata == 32'h0; endproperty
  a_un: assert property (p_un) else $error("unmapped read nonzero");
  property p_evt; rd_end && csr |-> (hrdata[31:26] & $past(cause_event, 2)) == $past(cause_event, 2); endproperty
  a_evt: assert property (p_evt) else $error("cause flag missing");
endmodule // rcsr_checker
bind rcsr_top rcsr_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .cause_event, .slow_rc_enable);
`default_nettype wire

/* tb/test_rcsr_top.sv */
// self-checking bench for rcsr_top over ahb-lite
// slow rc clock is shortened to 20 hclk and runs only when asked
`timescale 1ns/1ps
`default_nettype none
module test_rcsr_top;
  logic hclk, hresetn, power_resetn, hsel, hwrite, slow_rc_clk_pin;
  logic hreadyout, hresp, slow_rc_enable, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  rcsr_pkg::rcsr_cause_type cause_event;
  wire hready = hreadyout;
  int n_errors, tests_run;
  rcsr_top #(.START_CYCLES(2)) u_dut (.hclk, .hresetn, .power_resetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .cause_event,
    .slow_rc_clk_pin, .slow_rc_enable, .irq);
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task wrap_up;
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, seen);
      n_errors++;
    end
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      wrap_up;
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [2:0] s, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= s;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready;
  endtask
  task rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 3'h2, 32'h0);
    chk(name, hrdata, exp);
  endtask
  task irq_is(input logic exp);
    @(posedge hclk);
    chk("irq", {31'h0, irq}, {31'h0, exp});
  endtask
  task slow(input int k);
    repeat (k) begin
      slow_rc_clk_pin <= 1'b1;
      repeat (10) @(posedge hclk);
      slow_rc_clk_pin <= 1'b0;
      repeat (10) @(posedge hclk);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_causes;
    rd("csr_reset", 8'h24, 32'h0C00_0000);
    rd("unmapped", 8'h30, 32'h0);
    xfer(1'b1, 8'h24, 3'h2, 32'h0100_0000);
    rd("removed", 8'h24, 32'h0);
    for (int i = 0; i < 6; i++) begin
      cause_event <= rcsr_pkg::rcsr_cause_type'(6'h1 << i);
      @(posedge hclk);
      cause_event <= '0;
      rd("cause", 8'h24, 32'h0400_0000 << i);
      xfer(1'b1, 8'h27, 3'h0, 32'h0100_0000);
      rd("byte_remove", 8'h24, 32'h0);
    end
    cause_event <= 6'h3F;
    @(posedge hclk);
    cause_event <= '0;
    xfer(1'b1, 8'h24, 3'h2, 32'h0);
    rd("all_causes", 8'h24, 32'hFC00_0000);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd("sys_reset", 8'h24, 32'hFC00_0000);
    power_resetn <= 1'b0;
    repeat (2) @(posedge hclk);
    power_resetn <= 1'b1;
    @(posedge hclk);
    rd("pwr_reset", 8'h24, 32'h0C00_0000);
  endtask
  task t_slow_rc;
    xfer(1'b1, 8'h24, 3'h2, 32'h1);
    slow(2);
    rd("rc_ready", 8'h24, 32'h0C00_0003);
    irq_is(1'b0);
    xfer(1'b1, 8'h2C, 3'h2, 32'h1);
    irq_is(1'b1);
    xfer(1'b1, 8'h28, 3'h2, 32'h1);
    irq_is(1'b0);
    xfer(1'b1, 8'h24, 3'h2, 32'h0);
    slow(2);
    rd("rc_hold", 8'h24, 32'h0C00_0002);
    slow(1);
    rd("rc_off", 8'h24, 32'h0C00_0000);
    irq_is(1'b0);
  endtask
  initial begin
    n_errors = 0;
    tests_run = 0;
    hresetn = 1'b0;
    power_resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cause_event = '0;
    slow_rc_clk_pin = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    power_resetn <= 1'b1;
    @(posedge hclk);
    t_causes;
    t_slow_rc;
    wrap_up;
  end
endmodule // test_rcsr_top
`default_nettype wire
